//--- hdl/udr_setpoint_ramp.sv
// up/down key setpoint ramp with limits, save and routing
// What this block does
// - up key ramps output to upper limit
// - down key ramps output to lower limit
// - no key active: output held
// - rise uses rise time, fall uses fall time
// - third terminal activates or deactivates function
// - activation loads input, ramps into limits
// - deactivation action follows selector codes 0..5
// - inhibit, fault_shutdown, quick stop leave ramp alone
// - standard targets get -16384..+16384
// - scaling, gearbox, trim targets get -32767..+32767
// - routed target refuses direct writes
// - field-current target assignment is refused
// - main setpoint yields to stop, ramp, inching, direction
// - mains off saves output to nonvolatile store
// - power-up starts from saved or lower limit
// - hold-and-save reassignable to free analog input
// - limits span +-100.0% in 0.1% steps
// - times 1..5000 s per full-scale change
`timescale 1ns/1ps
module udr_setpoint_ramp #(
  parameter int TICK_CYCLES = udr_pkg::TICK_CYCLES_DEF
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic UP_TERMINAL,
  input wire logic DOWN_TERMINAL,
  input wire logic DEACTIVATE_TERMINAL,
  input wire logic MAINS_OFF,
  input wire logic signed [udr_pkg::SET_W-1:0] UPPER_LIMIT_SETTING,
  input wire logic signed [udr_pkg::SET_W-1:0] LOWER_LIMIT_SETTING,
  input wire logic [udr_pkg::TIME_W-1:0] RISE_TIME_SETTING,
  input wire logic [udr_pkg::TIME_W-1:0] FALL_TIME_SETTING,
  input wire logic [udr_pkg::SEL_W-1:0] DEACTIVATION_ACTION_SELECT,
  input wire logic POWER_UP_INIT_SELECT,
  input wire logic SH_REASSIGN,
  input wire logic signed [udr_pkg::VAL_W-1:0] SIGNAL_INPUT,
  input wire logic signed [udr_pkg::VAL_W-1:0] FREE_ANALOG_INPUT,
  input wire logic signed [udr_pkg::VAL_W-1:0] SAVED_VALUE,
  input wire logic ASSIGN_STROBE,
  input wire logic UNASSIGN_STROBE,
  input wire logic [udr_pkg::TGT_W-1:0] SIGNAL_TARGET_ASSIGN,
  input wire logic QUICK_STOP,
  input wire logic RAMP_GENERATOR_ACTIVE,
  input wire logic INCHING_ENABLE,
  input wire logic DIRECTION_CHANGEOVER,
  output logic signed [udr_pkg::VAL_W-1:0] VALUE_STD,
  output logic signed [udr_pkg::VAL_W-1:0] VALUE_WIDE,
  output logic signed [udr_pkg::VAL_W-1:0] ROUTE_VALUE,
  output logic ROUTE_VALID,
  output logic ROUTE_REFUSED,
  output logic DIRECT_WRITE_LOCK,
  output logic MAIN_SETPOINT_YIELD,
  output logic LIMIT_ERROR,
  output logic FUNCTION_ACTIVE,
  output logic signed [udr_pkg::VAL_W-1:0] SAVE_VALUE,
  output logic SAVE_STROBE
);
  localparam int AW = udr_pkg::ACC_W;
  localparam int VW = udr_pkg::VAL_W;
  localparam int NP = udr_pkg::NPIN;

  typedef struct packed {
    logic [NP-1:0][2:0] sy;
    logic [NP-1:0] lv;
    logic mains_d;
    udr_pkg::udr_state_t state;
    logic active;
    logic [31:0] tick_cnt;
    logic signed [AW-1:0] acc;
    logic [AW-1:0] rise_step;
    logic [AW-1:0] fall_step;
    logic signed [VW-1:0] sh;
    logic signed [VW-1:0] out_std;
    logic signed [VW-1:0] out_wide;
    logic signed [VW-1:0] route_val;
    logic route_valid;
    logic refused;
    logic assigned;
    logic [udr_pkg::TGT_W-1:0] target;
    logic yield;
    logic lim_err;
    logic signed [VW-1:0] save_val;
    logic save_stb;
  } udr_ramp_state_t;

  udr_ramp_state_t st_reg;
  udr_ramp_state_t st_next;

  udr_div_if #(.W(AW)) rise_if ();
  udr_div_if #(.W(AW)) fall_if ();

  logic [NP-1:0] pins;
  logic [udr_pkg::TIME_W-1:0] t_rise;
  logic [udr_pkg::TIME_W-1:0] t_fall;
  logic signed [AW-1:0] up_q;
  logic signed [AW-1:0] lo_q;
  logic signed [AW-1:0] src_q;
  logic lim_bad;
  logic tick;
  logic wide;
  logic prio;

  function automatic logic [udr_pkg::TIME_W-1:0] tclamp(
    input logic [udr_pkg::TIME_W-1:0] t
  );
    if (t < udr_pkg::TIME_MIN) begin
      return udr_pkg::TIME_MIN;
    end
    if (t > udr_pkg::TIME_MAX) begin
      return udr_pkg::TIME_MAX;
    end
    return t;
  endfunction

  // 33-bit sum so a large step near full scale cannot wrap
  function automatic logic signed [AW-1:0] ramp_to(
    input logic signed [AW-1:0] a,
    input logic signed [AW-1:0] t,
    input logic [AW-1:0] rs,
    input logic [AW-1:0] fs
  );
    logic signed [AW:0] s;
    s = '0;
    if (a < t) begin
      s = (AW+1)'(a) + $signed({1'b0, rs});
      if (s > (AW+1)'(t)) begin
        return t;
      end
      return s[AW-1:0];
    end
    if (a > t) begin
      s = (AW+1)'(a) - $signed({1'b0, fs});
      if (s < (AW+1)'(t)) begin
        return t;
      end
      return s[AW-1:0];
    end
    return a;
  endfunction

  function automatic logic signed [VW-1:0] clamp(
    input logic signed [AW-1:0] v,
    input logic signed [VW-1:0] lo,
    input logic signed [VW-1:0] hi
  );
    if (v > hi) begin
      return hi;
    end
    if (v < lo) begin
      return lo;
    end
    return v[VW-1:0];
  endfunction

  assign pins[udr_pkg::PIN_UP] = UP_TERMINAL;
  assign pins[udr_pkg::PIN_DOWN] = DOWN_TERMINAL;
  assign pins[udr_pkg::PIN_DEACT] = DEACTIVATE_TERMINAL;
  assign pins[udr_pkg::PIN_MAINS] = MAINS_OFF;

  // settings are range-checked here; out-of-range times are clamped
  assign t_rise = tclamp(RISE_TIME_SETTING);
  assign t_fall = tclamp(FALL_TIME_SETTING);
  assign up_q = UPPER_LIMIT_SETTING * udr_pkg::PERMIL_Q;
  assign lo_q = LOWER_LIMIT_SETTING * udr_pkg::PERMIL_Q;
  assign lim_bad = (up_q <= lo_q);

  // step = full scale / (time in ticks), refreshed continuously
  assign rise_if.dividend = udr_pkg::FULL_Q;
  assign rise_if.divisor = AW'(t_rise) * AW'(udr_pkg::TICKS_PER_S);
  assign fall_if.dividend = udr_pkg::FULL_Q;
  assign fall_if.divisor = AW'(t_fall) * AW'(udr_pkg::TICKS_PER_S);

  udr_divider #(.W(AW)) u_rise_div (
    .clk(CLK),
    .rst_n(RESETN),
    .div(rise_if)
  );

  udr_divider #(.W(AW)) u_fall_div (
    .clk(CLK),
    .rst_n(RESETN),
    .div(fall_if)
  );

  // held value in save mode replaces the ramp as source
  assign src_q = SH_REASSIGN ? {st_reg.sh, udr_pkg::FRAC_ZERO}
                             : st_reg.acc;

  assign wide = (st_reg.target >= udr_pkg::TGT_WIDE_LO) &&
                (st_reg.target <= udr_pkg::TGT_WIDE_HI);
  assign prio = QUICK_STOP | RAMP_GENERATOR_ACTIVE |
                INCHING_ENABLE | DIRECTION_CHANGEOVER;

  always_comb begin
    st_next = st_reg;
    st_next.save_stb = 1'b0;
    tick = 1'b0;

    // three-stage pin sync; a level counts once stages 2 and 3 agree
    for (int i = 0; i < NP; i++) begin
      st_next.sy[i] = {st_reg.sy[i][1:0], pins[i]};
      if (st_reg.sy[i][1] == st_reg.sy[i][2]) begin
        st_next.lv[i] = st_reg.sy[i][2];
      end
    end

    if (st_reg.tick_cnt == 32'(TICK_CYCLES - 1)) begin
      st_next.tick_cnt = '0;
      tick = 1'b1;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + 32'h0000_0001;
    end

    if (rise_if.done) begin
      st_next.rise_step = rise_if.quotient;
    end
    if (fall_if.done) begin
      st_next.fall_step = fall_if.quotient;
    end

    st_next.lim_err = lim_bad;

    // quick stop, inhibit and fault_shutdown are deliberately not looked at here
    unique case (st_reg.state)
      udr_pkg::ST_INIT: begin
        // wait one tick so the pin synchronisers have settled
        if (tick) begin
          if (POWER_UP_INIT_SELECT) begin
            st_next.acc = lo_q;
            st_next.sh = clamp(lo_q >>> udr_pkg::Q_FRAC,
                               udr_pkg::STD_MIN, udr_pkg::STD_MAX);
          end else begin
            st_next.acc = {SAVED_VALUE, udr_pkg::FRAC_ZERO};
            st_next.sh = SAVED_VALUE;
          end
          if (st_reg.lv[udr_pkg::PIN_DEACT]) begin
            st_next.state = udr_pkg::ST_DEACT;
          end else begin
            st_next.state = udr_pkg::ST_ACTIVE;
          end
        end
      end
      udr_pkg::ST_ACTIVE: begin
        if (st_reg.lv[udr_pkg::PIN_DEACT]) begin
          st_next.state = udr_pkg::ST_DEACT;
          case (DEACTIVATION_ACTION_SELECT)
            udr_pkg::DEACT_JUMP_ZERO: st_next.acc = '0;
            udr_pkg::DEACT_JUMP_LOW: st_next.acc = lo_q;
            default: st_next.acc = st_reg.acc;
          endcase
        end else begin
          st_next.sh = FREE_ANALOG_INPUT;
          if (tick && !lim_bad) begin
            if (st_reg.acc > up_q) begin
              st_next.acc = ramp_to(st_reg.acc, up_q, st_reg.rise_step,
                                    st_reg.fall_step);
            end else if (st_reg.acc < lo_q) begin
              st_next.acc = ramp_to(st_reg.acc, lo_q, st_reg.rise_step,
                                    st_reg.fall_step);
            end else if (st_reg.lv[udr_pkg::PIN_UP] &&
                         !st_reg.lv[udr_pkg::PIN_DOWN]) begin
              st_next.acc = ramp_to(st_reg.acc, up_q, st_reg.rise_step,
                                    st_reg.fall_step);
            end else if (st_reg.lv[udr_pkg::PIN_DOWN] &&
                         !st_reg.lv[udr_pkg::PIN_UP]) begin
              st_next.acc = ramp_to(st_reg.acc, lo_q, st_reg.rise_step,
                                    st_reg.fall_step);
            end else begin
              st_next.acc = st_reg.acc;
            end
          end
        end
      end
      udr_pkg::ST_DEACT: begin
        if (!st_reg.lv[udr_pkg::PIN_DEACT]) begin
          st_next.state = udr_pkg::ST_ACTIVE;
          st_next.acc = {SIGNAL_INPUT, udr_pkg::FRAC_ZERO};
        end else if (tick && !lim_bad) begin
          case (DEACTIVATION_ACTION_SELECT)
            udr_pkg::DEACT_RAMP_ZERO: begin
              st_next.acc = ramp_to(st_reg.acc, '0, st_reg.rise_step,
                                    st_reg.fall_step);
            end
            udr_pkg::DEACT_RAMP_LOW: begin
              st_next.acc = ramp_to(st_reg.acc, lo_q, st_reg.rise_step,
                                    st_reg.fall_step);
            end
            udr_pkg::DEACT_RAMP_HIGH: begin
              st_next.acc = ramp_to(st_reg.acc, up_q, st_reg.rise_step,
                                    st_reg.fall_step);
            end
            // hold, and the jumps already taken on the edge
            default: st_next.acc = st_reg.acc;
          endcase
        end
      end
    endcase

    // flag kept as its own flop so the port is not a state decode
    st_next.active = (st_next.state == udr_pkg::ST_ACTIVE);
    st_next.out_std = clamp(src_q >>> udr_pkg::Q_FRAC,
                            udr_pkg::STD_MIN, udr_pkg::STD_MAX);
    st_next.out_wide = clamp(src_q >>> (udr_pkg::Q_FRAC - 1),
                             udr_pkg::WIDE_MIN,
                             udr_pkg::WIDE_MAX);

    // capture on the synchronised edge of the mains-off signal
    st_next.mains_d = st_reg.lv[udr_pkg::PIN_MAINS];
    if (st_reg.lv[udr_pkg::PIN_MAINS] && !st_reg.mains_d) begin
      st_next.save_val = st_reg.out_std;
      st_next.save_stb = 1'b1;
    end

    if (UNASSIGN_STROBE) begin
      st_next.assigned = 1'b0;
      st_next.refused = 1'b0;
    end
    // assign wins when both strobes meet in one cycle
    if (ASSIGN_STROBE) begin
      if (SIGNAL_TARGET_ASSIGN == udr_pkg::TGT_FIELD_CUR) begin
        st_next.refused = 1'b1;
        st_next.assigned = 1'b0;
      end else begin
        st_next.refused = 1'b0;
        st_next.assigned = 1'b1;
        st_next.target = SIGNAL_TARGET_ASSIGN;
      end
    end

    st_next.route_val = wide ? st_reg.out_wide : st_reg.out_std;
    st_next.yield = st_reg.assigned && prio &&
                    (st_reg.target == udr_pkg::TGT_MAIN_SP);
    st_next.route_valid = st_reg.assigned && !st_next.yield;
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign VALUE_STD = st_reg.out_std;
  assign VALUE_WIDE = st_reg.out_wide;
  assign ROUTE_VALUE = st_reg.route_val;
  assign ROUTE_VALID = st_reg.route_valid;
  assign ROUTE_REFUSED = st_reg.refused;
  assign DIRECT_WRITE_LOCK = st_reg.assigned;
  assign MAIN_SETPOINT_YIELD = st_reg.yield;
  assign LIMIT_ERROR = st_reg.lim_err;
  assign FUNCTION_ACTIVE = st_reg.active;
  assign SAVE_VALUE = st_reg.save_val;
  assign SAVE_STROBE = st_reg.save_stb;
endmodule

//--- hdl/udr_pkg.sv
// constants and types shared by the up/down setpoint ramp
package udr_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_PERIOD_NS = 1_000_000;
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICKS_PER_S = 1_000_000_000 / TICK_PERIOD_NS;
  localparam int VAL_W = 16;
  localparam int ACC_W = 32;
  localparam int Q_FRAC = 16;
  localparam int SET_W = 11;
  localparam int TIME_W = 13;
  localparam int SEL_W = 3;
  localparam int TGT_W = 6;
  localparam int NPIN = 4;
  localparam int PIN_UP = 0;
  localparam int PIN_DOWN = 1;
  localparam int PIN_DEACT = 2;
  localparam int PIN_MAINS = 3;
  localparam logic [VAL_W-1:0] FRAC_ZERO = 16'h0000;
  localparam logic [ACC_W-1:0] FULL_Q = 32'h4000_0000;
  localparam logic signed [ACC_W-1:0] PERMIL_Q = 32'h0010_624E;
  localparam logic signed [VAL_W-1:0] STD_MAX = 16'h4000;
  localparam logic signed [VAL_W-1:0] STD_MIN = 16'hC000;
  localparam logic signed [VAL_W-1:0] WIDE_MAX = 16'h7FFF;
  localparam logic signed [VAL_W-1:0] WIDE_MIN = 16'h8001;
  localparam logic [TIME_W-1:0] TIME_MIN = 13'h0001;
  localparam logic [TIME_W-1:0] TIME_MAX = 13'h1388;
  localparam logic [TGT_W-1:0] TGT_MAIN_SP = 6'h01;
  localparam logic [TGT_W-1:0] TGT_FIELD_CUR = 6'h05;
  localparam logic [TGT_W-1:0] TGT_WIDE_LO = 6'h0A;
  localparam logic [TGT_W-1:0] TGT_WIDE_HI = 6'h0D;
  typedef enum logic [SEL_W-1:0] {
    DEACT_HOLD,
    DEACT_RAMP_ZERO,
    DEACT_RAMP_LOW,
    DEACT_JUMP_ZERO,
    DEACT_JUMP_LOW,
    DEACT_RAMP_HIGH
  } udr_deact_t;
  typedef enum logic [1:0] {ST_INIT, ST_ACTIVE, ST_DEACT} udr_state_t;
endpackage

//--- hdl/udr_div_if.sv
// request and answer of the step-size divider
`timescale 1ns/1ps
interface udr_div_if #(
  parameter int W = 32
);
  logic [W-1:0] dividend;
  logic [W-1:0] divisor;
  logic [W-1:0] quotient;
  logic done;
  modport req (output dividend, output divisor, input quotient, input done);
  modport srv (input dividend, input divisor, output quotient, output done);
endinterface

//--- hdl/udr_divider.sv
// free-running restoring divider for the ramp step size
`timescale 1ns/1ps
module udr_divider #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  udr_div_if.srv div
);
  localparam int CW = $clog2(W + 1);

  typedef struct packed {
    logic busy;
    logic [CW-1:0] cnt;
    logic [W-1:0] dsr;
    logic [W-1:0] rem;
    logic [W-1:0] quo;
    logic [W-1:0] res;
    logic done;
  } udr_div_state_t;

  udr_div_state_t st_reg;
  udr_div_state_t st_next;
  logic [W-1:0] trial;

  // one bit per cycle: slow, but a result every W+1 cycles is far
  // quicker than the default processing tick, and it keeps the area small
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    trial = {st_reg.rem[W-2:0], st_reg.quo[W-1]};
    if (!st_reg.busy) begin
      st_next.busy = 1'b1;
      st_next.cnt = CW'(W);
      st_next.dsr = div.divisor;
      st_next.rem = '0;
      st_next.quo = div.dividend;
    end else begin
      if (trial >= st_reg.dsr) begin
        st_next.rem = trial - st_reg.dsr;
        st_next.quo = {st_reg.quo[W-2:0], 1'b1};
      end else begin
        st_next.rem = trial;
        st_next.quo = {st_reg.quo[W-2:0], 1'b0};
      end
      st_next.cnt = st_reg.cnt - 1'b1;
      if (st_reg.cnt == CW'(1)) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
        st_next.res = st_next.quo;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign div.quotient = st_reg.res;
  assign div.done = st_reg.done;
endmodule

//--- sim/udr_setpoint_ramp_chk.sv
// port-level assertions for the up/down setpoint ramp
`timescale 1ns/1ps
module udr_setpoint_ramp_chk (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic UP_TERMINAL,
  input wire logic DOWN_TERMINAL,
  input wire logic DEACTIVATE_TERMINAL,
  input wire logic signed [udr_pkg::SET_W-1:0] UPPER_LIMIT_SETTING,
  input wire logic signed [udr_pkg::SET_W-1:0] LOWER_LIMIT_SETTING,
  input wire logic [udr_pkg::SEL_W-1:0] DEACTIVATION_ACTION_SELECT,
  input wire logic SH_REASSIGN,
  input wire logic ASSIGN_STROBE,
  input wire logic UNASSIGN_STROBE,
  input wire logic [udr_pkg::TGT_W-1:0] SIGNAL_TARGET_ASSIGN,
  input wire logic QUICK_STOP,
  input wire logic signed [udr_pkg::VAL_W-1:0] VALUE_STD,
  input wire logic ROUTE_VALID,
  input wire logic ROUTE_REFUSED,
  input wire logic DIRECT_WRITE_LOCK,
  input wire logic MAIN_SETPOINT_YIELD,
  input wire logic LIMIT_ERROR,
  input wire logic FUNCTION_ACTIVE,
  input wire logic signed [udr_pkg::VAL_W-1:0] SAVE_VALUE,
  input wire logic SAVE_STROBE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  sequence s_main_stop;
    ASSIGN_STROBE && SIGNAL_TARGET_ASSIGN == udr_pkg::TGT_MAIN_SP
      && QUICK_STOP ##1 QUICK_STOP && !ASSIGN_STROBE && !UNASSIGN_STROBE;
  endsequence
  sequence s_jump_zero;
    FUNCTION_ACTIVE && !DEACTIVATE_TERMINAL && !SH_REASSIGN ##1
      (DEACTIVATE_TERMINAL && !SH_REASSIGN
       && DEACTIVATION_ACTION_SELECT == 3'h3) [*7];
  endsequence
  // eight cycles: the key synchroniser lags four edges behind the pins
  sequence s_both_keys;
    (UP_TERMINAL && DOWN_TERMINAL && FUNCTION_ACTIVE && !SH_REASSIGN) [*8];
  endsequence
  chk_save_pulse: assert property (
    SAVE_STROBE |=> !SAVE_STROBE) else $error("save strobe too long");
  chk_save_value: assert property (
    SAVE_STROBE |-> SAVE_VALUE == $past(VALUE_STD))
    else $error("saved value differs from output");
  chk_field_refused: assert property (
    ASSIGN_STROBE && SIGNAL_TARGET_ASSIGN == udr_pkg::TGT_FIELD_CUR
    |=> ROUTE_REFUSED && !DIRECT_WRITE_LOCK)
    else $error("field current target accepted");
  chk_assign_lock: assert property (
    ASSIGN_STROBE && SIGNAL_TARGET_ASSIGN != udr_pkg::TGT_FIELD_CUR
    |=> DIRECT_WRITE_LOCK && !ROUTE_REFUSED)
    else $error("assigned target not locked");
  chk_unassign_free: assert property (
    UNASSIGN_STROBE && !ASSIGN_STROBE |=> !DIRECT_WRITE_LOCK)
    else $error("lock kept after unassign");
  chk_main_yield: assert property (
    s_main_stop |=> MAIN_SETPOINT_YIELD && !ROUTE_VALID)
    else $error("main setpoint did not yield");
  chk_deact_off: assert property (
    DEACTIVATE_TERMINAL [*6] |-> !FUNCTION_ACTIVE)
    else $error("function active while deactivated");
  chk_jump_zero: assert property (
    s_jump_zero |-> VALUE_STD == 16'h0000)
    else $error("jump to zero too late");
  chk_both_hold: assert property (
    s_both_keys |-> $stable(VALUE_STD))
    else $error("output moved with both keys");
  chk_limit_flag: assert property (
    ($stable(UPPER_LIMIT_SETTING) && $stable(LOWER_LIMIT_SETTING)) [*3]
    |-> LIMIT_ERROR == (UPPER_LIMIT_SETTING <= LOWER_LIMIT_SETTING))
    else $error("limit error flag wrong");
endmodule
bind udr_setpoint_ramp udr_setpoint_ramp_chk chk_i (.CLK(CLK),
  .RESETN(RESETN), .UP_TERMINAL(UP_TERMINAL),
  .DOWN_TERMINAL(DOWN_TERMINAL), .DEACTIVATE_TERMINAL(DEACTIVATE_TERMINAL),
  .UPPER_LIMIT_SETTING(UPPER_LIMIT_SETTING),
  .LOWER_LIMIT_SETTING(LOWER_LIMIT_SETTING),
  .DEACTIVATION_ACTION_SELECT(DEACTIVATION_ACTION_SELECT),
  .SH_REASSIGN(SH_REASSIGN), .ASSIGN_STROBE(ASSIGN_STROBE),
  .UNASSIGN_STROBE(UNASSIGN_STROBE),
  .SIGNAL_TARGET_ASSIGN(SIGNAL_TARGET_ASSIGN), .QUICK_STOP(QUICK_STOP),
  .VALUE_STD(VALUE_STD), .ROUTE_VALID(ROUTE_VALID),
  .ROUTE_REFUSED(ROUTE_REFUSED), .DIRECT_WRITE_LOCK(DIRECT_WRITE_LOCK),
  .MAIN_SETPOINT_YIELD(MAIN_SETPOINT_YIELD), .LIMIT_ERROR(LIMIT_ERROR),
  .FUNCTION_ACTIVE(FUNCTION_ACTIVE), .SAVE_VALUE(SAVE_VALUE),
  .SAVE_STROBE(SAVE_STROBE));

//--- sim/udr_term_model.sv
// model of the terminal block and the signal routing matrix
`timescale 1ns/1ps
module udr_term_model (
  input wire logic clk,
  output logic up,
  output logic down,
  output logic deact,
  output logic mains,
  output logic assign_stb,
  output logic unassign_stb,
  output logic [udr_pkg::TGT_W-1:0] target
);
  initial begin
    up = 1'h0;
    down = 1'h0;
    deact = 1'h0;
    mains = 1'h0;
    assign_stb = 1'h0;
    unassign_stb = 1'h0;
    target = 6'h00;
  end
  // pins are raw levels; debouncing is the block's job
  task automatic keys(input logic u, input logic d);
    @(negedge clk);
    up = u;
    down = d;
  endtask
  task automatic set_deact(input logic x);
    @(negedge clk);
    deact = x;
  endtask
  task automatic set_mains(input logic x);
    @(negedge clk);
    mains = x;
  endtask
  // strobes last exactly one cycle, target stands until the next one
  task automatic route(input logic [udr_pkg::TGT_W-1:0] t, input logic add);
    @(negedge clk);
    target = t;
    assign_stb = add;
    unassign_stb = !add;
    @(negedge clk);
    assign_stb = 1'h0;
    unassign_stb = 1'h0;
  endtask
endmodule

//--- sim/udr_setpoint_ramp_tb.sv
// self-checking bench for the up/down setpoint ramp
`timescale 1ns/1ps
module udr_setpoint_ramp_tb;
  logic clk, resetn, pinit, shr, up, down, deact, mains, a_stb, u_stb;
  logic signed [udr_pkg::SET_W-1:0] upper, lower;
  logic [udr_pkg::TIME_W-1:0] tr, tf;
  logic [udr_pkg::SEL_W-1:0] sel;
  logic signed [udr_pkg::VAL_W-1:0] sig, free_analog_input, saved, v_std, v_wide, r_val;
  logic signed [udr_pkg::VAL_W-1:0] s_val;
  logic [udr_pkg::TGT_W-1:0] tgt;
  logic [3:0] prio;
  logic r_valid, r_ref, lock, yield, lerr, fact, s_stb;
  logic [31:0] seed = 32'h014CD8EF;
  logic [31:0] got;
  int mismatches = 0;
  int n_compared = 0;
  int up_l, lo_l, cur, t;
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  udr_term_model udr_term_model_i (.clk(clk), .up(up), .down(down),
    .deact(deact), .mains(mains), .assign_stb(a_stb),
    .unassign_stb(u_stb), .target(tgt));
  // short tick keeps full-scale ramps within a few thousand cycles
  udr_setpoint_ramp #(.TICK_CYCLES(8)) udr_setpoint_ramp_i (.CLK(clk),
    .RESETN(resetn), .UP_TERMINAL(up), .DOWN_TERMINAL(down),
    .DEACTIVATE_TERMINAL(deact), .MAINS_OFF(mains),
    .UPPER_LIMIT_SETTING(upper), .LOWER_LIMIT_SETTING(lower),
    .RISE_TIME_SETTING(tr), .FALL_TIME_SETTING(tf),
    .DEACTIVATION_ACTION_SELECT(sel), .POWER_UP_INIT_SELECT(pinit),
    .SH_REASSIGN(shr), .SIGNAL_INPUT(sig), .FREE_ANALOG_INPUT(free_analog_input),
    .SAVED_VALUE(saved), .ASSIGN_STROBE(a_stb), .UNASSIGN_STROBE(u_stb),
    .SIGNAL_TARGET_ASSIGN(tgt), .QUICK_STOP(prio[0]),
    .RAMP_GENERATOR_ACTIVE(prio[1]), .INCHING_ENABLE(prio[2]),
    .DIRECTION_CHANGEOVER(prio[3]), .VALUE_STD(v_std),
    .VALUE_WIDE(v_wide), .ROUTE_VALUE(r_val), .ROUTE_VALID(r_valid),
    .ROUTE_REFUSED(r_ref), .DIRECT_WRITE_LOCK(lock),
    .MAIN_SETPOINT_YIELD(yield), .LIMIT_ERROR(lerr),
    .FUNCTION_ACTIVE(fact), .SAVE_VALUE(s_val), .SAVE_STROBE(s_stb));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int lim_val(input int l);
    return (l * 1073742) >>> 16;
  endfunction
  function automatic int step_q(input int s);
    return (1 << 30) / (s * 1000);
  endfunction
  function automatic int exp_deact(input int c, input int v);
    case (c)
      1, 3: return 0;
      2, 4: return lim_val(lo_l);
      5: return lim_val(up_l);
      default: return v;
    endcase
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // both samples sit at the same tick phase, so the floor may add one
  task automatic ramp_rate(input int s, input int dir);
    int v0, lo, d;
    // a new time needs up to two divider rounds before its step is used
    cyc(72);
    v0 = int'(v_std);
    cyc(80);
    d = (int'(v_std) - v0) * dir;
    lo = 10 * step_q(s) / 65536;
    check("ramp delta", 32'(d >= lo && d <= lo + 1), 32'h1);
  endtask
  task automatic wait_save(output logic [31:0] seen);
    udr_term_model_i.set_mains(1'h1);
    for (int n = 0; n < 12; n++) begin
      @(posedge clk);
      #1;
      if (s_stb === 1'h1) break;
    end
    check("save strobe", 32'(s_stb), 32'h1);
    seen = 32'(s_val);
    udr_term_model_i.set_mains(1'h0);
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    resetn = 1'h0;
    pinit = 1'h0;
    shr = 1'h0;
    prio = 4'h0;
    upper = 11'h1F4;
    lower = 11'h60C;
    tr = 13'h000A;
    tf = 13'h000A;
    sel = 3'h0;
    sig = 16'h0000;
    free_analog_input = 16'h0000;
    saved = 16'(int'(rnd() % 8000) - 4000);
    cyc(7);
    check("reset value", v_std, 32'h0);
    cyc(1);
    resetn = 1'h1;
    cyc(60);
    check("power-up value", v_std, saved);
    check("active", 32'(fact), 32'h1);
    for (int k = 0; k < 2; k++) begin
      t = 1 + int'(rnd() % 8);
      tr = 13'(t);
      tf = 13'(t % 8 + 1);
      udr_term_model_i.keys(1'h1, 1'h0);
      ramp_rate(t, 1);
      udr_term_model_i.keys(1'h0, 1'h1);
      ramp_rate(t % 8 + 1, -1);
    end
    up_l = 100 + int'(rnd() % 200);
    lo_l = -100 - int'(rnd() % 200);
    upper = 11'(up_l);
    lower = 11'(lo_l);
    tr = 13'h0001;
    tf = 13'h0001;
    udr_term_model_i.keys(1'h1, 1'h0);
    cyc(5200);
    check("upper limit", v_std, lim_val(up_l));
    udr_term_model_i.keys(1'h0, 1'h1);
    cyc(5200);
    cur = lim_val(lo_l);
    check("lower limit", v_std, cur);
    udr_term_model_i.keys(1'h1, 1'h1);
    cyc(100);
    check("both keys", v_std, cur);
    udr_term_model_i.keys(1'h0, 1'h0);
    cyc(100);
    check("no keys", v_std, cur);
    for (int c = 0; c < 6; c++) begin
      if (c > 0) begin
        sig = 16'(lim_val(lo_l) + 1 + int'(rnd() % 1000));
        udr_term_model_i.set_deact(1'h0);
        cyc(20);
        check("activation load", v_std, sig);
        cur = int'(sig);
      end
      sel = 3'(c);
      udr_term_model_i.set_deact(1'h1);
      cyc(6);
      if (c == 3 || c == 4) check("jump", v_std, exp_deact(c, cur));
      cyc(5200);
      cur = exp_deact(c, cur);
      check("deactivation", v_std, cur);
    end
    sig = 16'h2000;
    udr_term_model_i.set_deact(1'h0);
    cyc(3600);
    cur = lim_val(up_l);
    check("activation clamp", v_std, cur);
    wait_save(got);
    check("saved value", got, cur);
    shr = 1'h1;
    free_analog_input = 16'h4000;
    cyc(10);
    check("std top", v_std, 32'h4000);
    check("wide top", v_wide, 32'h7FFF);
    free_analog_input = 16'hC000;
    cyc(10);
    check("std bottom", v_std, -16384);
    check("wide bottom", v_wide, -32767);
    wait_save(got);
    check("sampled save", got, -16384);
    udr_term_model_i.set_deact(1'h1);
    cyc(6);
    free_analog_input = 16'h1000;
    cyc(10);
    check("sample held", v_std, -16384);
    shr = 1'h0;
    udr_term_model_i.route(udr_pkg::TGT_FIELD_CUR, 1'h1);
    cyc(2);
    check("refused", 32'({r_ref, lock}), 32'h2);
    for (int k = 0; k < 4; k++) begin
      prio = 4'(1 << k);
      udr_term_model_i.route(udr_pkg::TGT_MAIN_SP, 1'h1);
      cyc(2);
      check("yield", 32'({yield, r_valid}), 32'h2);
      check("stop ignored", v_std, cur);
      prio = 4'h0;
      cyc(3);
      check("released", 32'({yield, r_valid}), 32'h1);
    end
    udr_term_model_i.route(6'(10 + rnd() % 4), 1'h1);
    cyc(3);
    check("wide route", r_val, (up_l * 1073742) >>> 15);
    udr_term_model_i.route(6'h02, 1'h1);
    cyc(3);
    check("std route", r_val, cur);
    check("locked", 32'(lock), 32'h1);
    udr_term_model_i.route(6'h02, 1'h0);
    cyc(2);
    check("unlocked", 32'(lock), 32'h0);
    upper = lower;
    cyc(5);
    check("limit error", 32'(lerr), 32'h1);
    upper = 11'(up_l);
    cyc(5);
    check("limit ok", 32'(lerr), 32'h0);
    udr_term_model_i.set_deact(1'h0);
    pinit = 1'h1;
    saved = 16'h0ABC;
    resetn = 1'h0;
    cyc(8);
    resetn = 1'h1;
    cyc(60);
    check("power-up low", v_std, lim_val(lo_l));
    check("active again", 32'(fact), 32'h1);
    tally_and_finish();
  end
endmodule
